// File: core/dotp_pkg.sv
// constants, register map and types of the overload and thermal protection
// assumes a 250 MHz control clock and percent-scaled current samples
package dotp_pkg;

  // clock and control period
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned CTRL_PERIOD_NS = 100_000;   // filter update period
  localparam int unsigned TICK_CYC       =
    (CLK_HZ / 1_000_000) * (CTRL_PERIOD_NS / 1_000);
  localparam int unsigned TICKS_PER_S    = 1_000_000_000 / CTRL_PERIOD_NS;

  // bus widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // current scaling
  localparam int unsigned AMP_RATING_A = 10;  // amplifier rating, amperes
  localparam int unsigned PCT_FULL     = 100; // percent scale
  localparam int unsigned I2T_DIV      = 50;  // i2t signal divisor
  localparam int unsigned PEAK_K       = 4;   // peak time factor, seconds
  localparam int unsigned CLAMP_NUM    = 7;   // 0.7 as 7 / 10
  localparam int unsigned CLAMP_DEN    = 10;
  localparam int unsigned REL_NUM      = 289; // 0.85 squared as 289 / 400
  localparam int unsigned REL_DEN      = 400;
  localparam int unsigned FILT_SH      = 6;   // filter time constant shift

  // register offsets (word index)
  localparam logic [ADDR_W-1:0] REG_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_RATED = 4'h1;
  localparam logic [ADDR_W-1:0] REG_MAX   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_WARN  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_TRIP  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STAT  = 4'h5;
  localparam logic [ADDR_W-1:0] REG_MASK  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_I2T   = 4'h7;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h8;

  // field positions
  localparam int unsigned CTRL_LIM_BIT = 0;  // 1 = limiting mode
  localparam int unsigned CTRL_PTC_BIT = 1;  // 1 = positive coeff sensor
  localparam int unsigned EV_OVL       = 0;
  localparam int unsigned EV_THM       = 1;
  localparam int unsigned EV_WARN      = 2;
  localparam int unsigned EV_CLAMP     = 3;
  localparam int unsigned NUM_EV       = 4;

  // reset values
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [7:0]  RATED_RST  = 8'h05;
  localparam logic [7:0]  MAX_RST    = 8'h0a;
  localparam logic [15:0] OHM_RST    = 16'h0ce4;  // 3300 ohm, near 140 C

  typedef enum logic [1:0] {
    OL_NORMAL,
    OL_PEAK,
    OL_CLAMP,
    OL_TRIP
  } dotp_ol_e;

endpackage

// File: core/dotp_protect.sv
// i2t overload and motor thermal protection with a small register port
// assumes current samples and sensor ohms come from logic on clk_in
`timescale 1ns/10ps

// How it works
// - fusing: no drop under 85% trips
// - rms at rated clamps command to rated
// - peak allowed 4*rated^2/max^2 seconds
// - clamp lasts 1-0.7*rated^2/max^2 seconds, fusing
// - timing exact only above 1.5 ratio
// - max equals rated: never trip, hold
// - warning threshold lights panel, stays enabled
// - trip threshold disables the power stage
// - ntc crosses downward, ptc crosses upward
// - default trip near 3.3 kohm
// - rated percent is 100*rated/amp rating
// - limit threshold is rated percent squared/50
// - rms equals sqrt(50*signal)*rating/100
// - torque mode, zero command, zero torque
// - limiting mode: same peak, then hold
// - any fault opens the drive-ok relay
module dotp_protect #(
  parameter int unsigned TICK_CYC_P = dotp_pkg::TICK_CYC
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic [dotp_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [dotp_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [dotp_pkg::DATA_W-1:0] rd_data_out,
  input  wire logic                        drive_enable_in,
  input  wire logic                        fault_reset_in,
  input  wire logic                        torque_mode_select_in,
  input  wire logic signed [8:0]           cmd_in,
  input  wire logic [7:0]                  meas_cur_in,
  input  wire logic [15:0]                 sensor_ohm_in,
  output logic signed [8:0]                cmd_out,
  output logic                             power_enable_out,
  output logic                             drive_ok_relay_out,
  output logic                             temp_warn_out,
  output logic                             irq_out
);
  import dotp_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC_P - 1);

  // pin synchronisers: enable, fault reset, torque mode
  logic [2:0]          pin_a_r;       // first stage, read by pin_b_r only
  logic [2:0]          pin_b_r;       // second stage
  logic                en_s;
  logic                frst_s;
  logic                tq_s;

  // configuration and interrupt registers
  logic [1:0]          ctrl_r;
  logic [7:0]          rated_a_r;     // rated current, amperes
  logic [7:0]          max_a_r;       // maximum current, amperes
  logic [15:0]         warn_ohm_r;
  logic [15:0]         trip_ohm_r;
  logic [NUM_EV-1:0]   stat_r;        // sticky events
  logic [NUM_EV-1:0]   mask_r;
  logic [NUM_EV-1:0]   stat_nxt;
  logic [NUM_EV-1:0]   lvl;           // event source levels
  logic [NUM_EV-1:0]   lvl_q_r;       // previous levels for edges

  // current path
  logic [15:0]         tick_cnt_r;
  logic                tick;
  logic [7:0]          rated_pct;
  logic [7:0]          max_pct;
  logic [15:0]         r2;
  logic [15:0]         m2;
  logic [15:0]         sq;
  logic [15:0]         est_r;         // filtered current squared, %^2
  logic signed [17:0]  diff;
  logic signed [17:0]  est_sum;
  logic [15:0]         i2t_sig;       // i2t signal, percent squared over 50
  logic [15:0]         lim_thr;
  logic                at_rated;
  logic                over;
  logic                drop;
  logic                equal;
  logic [33:0]         acc_r;         // overload time bucket
  logic [33:0]         peak_thr;
  logic [33:0]         clamp_step;
  logic [33:0]         clamp_thr;
  dotp_ol_e            ol_st_r;

  // thermal and outputs
  logic                hot_warn;
  logic                hot_trip;
  logic                thm_flt_r;
  logic                fault;
  logic [7:0]          lim;
  logic [8:0]          mag;
  logic [8:0]          clamped;

  assign en_s   = pin_b_r[0];
  assign frst_s = pin_b_r[1];
  assign tq_s   = pin_b_r[2];

  // two flops per pin, only the second stage reads the first
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_a_r <= '0;
      pin_b_r <= '0;
    end else begin
      pin_a_r <= {torque_mode_select_in, fault_reset_in, drive_enable_in};
      pin_b_r <= pin_a_r;
    end
  end

  // configuration writes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_r     <= CTRL_RST;
      rated_a_r  <= RATED_RST;
      max_a_r    <= MAX_RST;
      warn_ohm_r <= OHM_RST;
      trip_ohm_r <= OHM_RST;
      mask_r     <= '0;
    end else if (wr_in) begin
      case (addr_in)
        REG_CTRL:  ctrl_r     <= wr_data_in[1:0];
        REG_RATED: rated_a_r  <= wr_data_in[7:0];
        REG_MAX:   max_a_r    <= wr_data_in[7:0];
        REG_WARN:  warn_ohm_r <= wr_data_in;
        REG_TRIP:  trip_ohm_r <= wr_data_in;
        REG_MASK:  mask_r     <= wr_data_in[NUM_EV-1:0];
        default:   ;                            // status cleared in the event logic; others read-only or unmapped
      endcase
    end
  end

  // scaled currents; division by a constant only
  always_comb begin
    rated_pct = 8'(PCT_FULL * rated_a_r / AMP_RATING_A);
    max_pct   = 8'(PCT_FULL * max_a_r / AMP_RATING_A);
    r2        = rated_pct * rated_pct;
    m2        = max_pct * max_pct;
    sq        = meas_cur_in * meas_cur_in;
    i2t_sig   = 16'(est_r / I2T_DIV);
    lim_thr   = 16'(r2 / I2T_DIV);
    at_rated  = (i2t_sig >= lim_thr);
    over      = (meas_cur_in > rated_pct);
    drop      = (26'(est_r) * 26'(REL_DEN)) < (26'(r2) * 26'(REL_NUM));
    equal     = (max_pct == rated_pct);
    diff      = $signed({2'b00, sq}) - $signed({2'b00, est_r});
    est_sum   = $signed({2'b00, est_r}) + (diff >>> FILT_SH);
    // bucket filled with i^2 reaches 4*r^2 after 4*r^2/m^2 seconds
    peak_thr  = 34'(PEAK_K * TICKS_PER_S) * 34'(r2);
    clamp_step = 34'(CLAMP_DEN) * 34'(m2);
    // thr/step in seconds = 1 - 0.7*r^2/m^2; figures hold above 1.5 ratio
    if (clamp_step > 34'(CLAMP_NUM) * 34'(r2))
      clamp_thr = (clamp_step - 34'(CLAMP_NUM) * 34'(r2))
                  * 34'(TICKS_PER_S);
    else
      clamp_thr = '0;
  end

  // control period tick
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      tick_cnt_r <= '0;
    else if (tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 16'h0001;
  end
  assign tick = (tick_cnt_r == TICK_LAST);

  // first order filter, settles to mean of i^2
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      est_r <= '0;
    else if (tick)
      est_r <= est_sum[15:0];
  end

  // overload sequence: peak, clamp, trip
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ol_st_r <= OL_NORMAL;
      acc_r   <= '0;
    end else if (frst_s) begin
      ol_st_r <= OL_NORMAL;
      acc_r   <= '0;
    end else if (tick) begin
      case (ol_st_r)
        OL_NORMAL: begin
          if (over) begin
            ol_st_r <= OL_PEAK;
            acc_r   <= acc_r + 34'(sq);
          end else if (acc_r > 34'(r2)) begin
            acc_r   <= acc_r - 34'(r2);        // cool down slowly
          end else begin
            acc_r   <= '0;
          end
        end
        OL_PEAK: begin
          if (at_rated || acc_r >= peak_thr) begin
            ol_st_r <= OL_CLAMP;
            acc_r   <= '0;
          end else if (!over) begin
            ol_st_r <= OL_NORMAL;
          end else begin
            acc_r   <= acc_r + 34'(sq);
          end
        end
        OL_CLAMP: begin
          // rms fell under 85%: overload over, no trip
          if (drop) begin
            ol_st_r <= OL_NORMAL;
            acc_r   <= '0;
          end else if (ctrl_r[CTRL_LIM_BIT] || equal) begin
            acc_r   <= acc_r;
          end else if (acc_r >= clamp_thr) begin
            ol_st_r <= OL_TRIP;
          end else begin
            acc_r   <= acc_r + clamp_step;
          end
        end
        OL_TRIP: ol_st_r <= OL_TRIP;
        default: ol_st_r <= OL_NORMAL;
      endcase
    end
  end

  // sensor crossing direction depends on probe type
  always_comb begin
    if (ctrl_r[CTRL_PTC_BIT]) begin
      hot_warn = (sensor_ohm_in >= warn_ohm_r);
      hot_trip = (sensor_ohm_in >= trip_ohm_r);
    end else begin
      hot_warn = (sensor_ohm_in <= warn_ohm_r);
      hot_trip = (sensor_ohm_in <= trip_ohm_r);
    end
  end

  // thermal fault latch; a still-hot motor wins over reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      thm_flt_r <= 1'b0;
    else if (hot_trip)
      thm_flt_r <= 1'b1;
    else if (frst_s)
      thm_flt_r <= 1'b0;
  end

  assign fault = thm_flt_r || (ol_st_r == OL_TRIP);

  // command clamp; zero in gives zero out
  always_comb begin
    lim     = (ol_st_r == OL_CLAMP) ? rated_pct : max_pct;
    mag     = cmd_in[8] ? 9'(-cmd_in) : 9'(cmd_in);
    clamped = (mag > {1'b0, lim}) ? {1'b0, lim} : mag;
  end

  // power stage, relay, panel and command outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmd_out            <= '0;
      power_enable_out   <= 1'b0;
      drive_ok_relay_out <= 1'b0;
      temp_warn_out      <= 1'b0;
    end else begin
      power_enable_out   <= en_s && !fault;
      drive_ok_relay_out <= !fault;
      temp_warn_out      <= hot_warn;
      if (!en_s || fault)
        cmd_out <= '0;
      else if (cmd_in[8])
        cmd_out <= -$signed(clamped);
      else
        cmd_out <= $signed(clamped);
    end
  end

  // sticky events, set wins over a one-to-clear
  always_comb begin
    lvl           = '0;
    lvl[EV_OVL]   = (ol_st_r == OL_TRIP);
    lvl[EV_THM]   = thm_flt_r;
    lvl[EV_WARN]  = hot_warn;
    lvl[EV_CLAMP] = (ol_st_r == OL_CLAMP);
    stat_nxt      = stat_r;
    if (wr_in && addr_in == REG_STAT)
      stat_nxt = stat_r & ~wr_data_in[NUM_EV-1:0];
    stat_nxt = stat_nxt | (lvl & ~lvl_q_r);
  end

  // interrupt state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stat_r  <= '0;
      lvl_q_r <= '0;
      irq_out <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      lvl_q_r <= lvl;
      irq_out <= |(stat_nxt & mask_r);
    end
  end

  // read port: data valid one cycle after the strobe only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !rd_in) begin
      rd_data_out <= '0;
    end else begin
      case (addr_in)
        REG_CTRL:  rd_data_out <= {14'h0000, ctrl_r};
        REG_RATED: rd_data_out <= {8'h00, rated_a_r};
        REG_MAX:   rd_data_out <= {8'h00, max_a_r};
        REG_WARN:  rd_data_out <= warn_ohm_r;
        REG_TRIP:  rd_data_out <= trip_ohm_r;
        REG_STAT:  rd_data_out <= {12'h000, stat_r};
        REG_MASK:  rd_data_out <= {12'h000, mask_r};
        REG_I2T:   rd_data_out <= i2t_sig;
        REG_STATE: rd_data_out <= {rated_pct, 5'h00, thm_flt_r, ol_st_r};
        default:   rd_data_out <= '0;          // unmapped reads zero
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [8:0] out_mag;
  assign out_mag = cmd_out[8] ? 9'(-cmd_out) : 9'(cmd_out);

  sequence s_clamp_drop;
    ol_st_r == OL_CLAMP && tick && drop && !frst_s;
  endsequence

  sequence s_hot;
    hot_trip ##1 thm_flt_r;
  endsequence

  chk_drop_release: assert property (
    s_clamp_drop |=> ol_st_r == OL_NORMAL)
    else $error("clamp not released on rms drop");

  chk_clamp_limit: assert property (
    ol_st_r == OL_CLAMP |=> out_mag <= {1'b0, $past(rated_pct)})
    else $error("command above rated in clamp");

  chk_equal_notrip: assert property (
    ol_st_r == OL_CLAMP && equal |=> ol_st_r != OL_TRIP)
    else $error("trip with max equal to rated");

  chk_limit_notrip: assert property (
    ol_st_r != OL_TRIP && ctrl_r[CTRL_LIM_BIT] |=> ol_st_r != OL_TRIP)
    else $error("trip in limiting mode");

  chk_warn_enabled: assert property (
    hot_warn && !hot_trip && !fault && en_s |=> power_enable_out)
    else $error("warning disabled the drive");

  chk_hot_disable: assert property (
    s_hot |=> !power_enable_out && !drive_ok_relay_out)
    else $error("hot sensor left drive enabled");

  chk_relay_open: assert property (
    fault |=> !drive_ok_relay_out)
    else $error("relay closed during fault");

  chk_fault_latch: assert property (
    ol_st_r == OL_TRIP && !frst_s |=> ol_st_r == OL_TRIP)
    else $error("overload fault lost without reset");

  chk_zero_torque: assert property (
    tq_s && cmd_in == 9'h000 |=> cmd_out == 9'h000)
    else $error("torque with zero command");

  chk_filter_tick: assert property (
    !tick |=> est_r == $past(est_r))
    else $error("estimate moved between ticks");

endmodule

// File: verif/dotp_motor_model.sv
// motor stand-in: phase current magnitude and thermal probe resistance
// assumes the protection block's command and power enable on clk_in
`timescale 1ns/10ps
module dotp_motor_model (
  input  wire logic              clk_in,
  input  wire logic signed [8:0] cmd_in,
  input  wire logic              power_in,
  input  wire logic [15:0]       probe_ohm_in,
  output logic      [7:0]        meas_cur_out,
  output logic      [15:0]       sensor_ohm_out
);
  // current tracks the command magnitude one cycle late
  // an unpowered stage carries no current at all
  always_ff @(posedge clk_in) begin
    if (!power_in) begin
      meas_cur_out <= 8'h00;
    end else if (cmd_in < 0) begin
      meas_cur_out <= 8'(-cmd_in);
    end else begin
      meas_cur_out <= 8'(cmd_in);
    end
  end
  // probe follows the bench's temperature setting
  always_ff @(posedge clk_in) begin
    sensor_ohm_out <= probe_ohm_in;
  end
endmodule

// File: verif/tb_drive_overload_thermal_protect.sv
// self-checking bench for the overload and thermal protection block
// assumes dotp_pkg compiled first; control tick shortened to two cycles
`timescale 1ns/10ps
module tb_drive_overload_thermal_protect;
  import dotp_pkg::*;
  logic              clk_in;   // 250 MHz
  logic              rst_n_in; // sync, active low
  logic [3:0]        addr;
  logic [15:0]       wdat;
  logic              wr;
  logic              rd;
  logic [15:0]       rdat;
  logic              drv_en;
  logic              flt_rst;
  logic              trq_sel;
  logic signed [8:0] cmd;
  logic [7:0]        meas;
  logic [15:0]       ohm;
  logic [15:0]       probe;
  logic signed [8:0] cmd_o;
  logic              pwr;
  logic              relay;
  logic              warn;
  logic              irq;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                cyc = 0;
  int                i;
  int                j;
  logic [15:0]       v;
  // reset values by word index 0..8
  logic [15:0] rst_exp [9] = '{16'h0000, 16'h0005, 16'h000a, 16'h0ce4,
    16'h0ce4, 16'h0000, 16'h0000, 16'h0000, 16'h3200};
  // probe ohms per thermal case, three ntc then three ptc
  logic [15:0] th_ohm [6] = '{16'h1388, 16'h0ed8, 16'h0bb8, 16'h03e8,
    16'h09c4, 16'h0e10};
  logic [1:0]  th_exp [6] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h3, 2'h2};

  dotp_protect #(.TICK_CYC_P(2)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
    .drive_enable_in(drv_en), .fault_reset_in(flt_rst),
    .torque_mode_select_in(trq_sel), .cmd_in(cmd), .meas_cur_in(meas),
    .sensor_ohm_in(ohm), .cmd_out(cmd_o), .power_enable_out(pwr),
    .drive_ok_relay_out(relay), .temp_warn_out(warn), .irq_out(irq));

  dotp_motor_model motor_u (
    .clk_in(clk_in), .cmd_in(cmd_o), .power_in(pwr),
    .probe_ohm_in(probe), .meas_cur_out(meas), .sensor_ohm_out(ohm));

  // free-running clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // hang guard, well above the roughly 50k cycles the tests need
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one-cycle write strobe
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk_in);
    wr   <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1 d = rdat;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rreg(a, d);
    chk(d, e);
  endtask

  // pin pulse long enough for the synchronisers, then wipe status
  task automatic clear_faults();
    flt_rst <= 1'b1;
    step(4);
    flt_rst <= 1'b0;
    step(4);
    wreg(REG_STAT, 16'h000f);
  endtask

  // sustained overload that must settle at rated and never trip
  task automatic overload_hold(input logic [15:0] c, input logic [15:0] m);
    wreg(REG_CTRL, c);
    wreg(REG_MAX, m);
    cmd <= 9'sd100;
    step(12000);
    chk({15'h0, pwr}, 16'h0001);
    chk({7'h0, cmd_o}, 16'h0032);
    rreg(REG_I2T, v);
    chk({15'h0, v >= 16'd40 && v <= 16'd50}, 16'h0001);
    cmd <= 9'sd0;
    step(20);
  endtask

  initial begin
    rst_n_in = 1'b0;
    addr = 4'h0;
    wdat = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    drv_en = 1'b1;
    flt_rst = 1'b0;
    trq_sel = 1'b0;
    cmd = 9'sd0;
    probe = 16'h1388;
    step(3);
    rst_n_in <= 1'b1;
    step(3);
    // register reset values, then an unmapped word
    for (i = 0; i < 9; i++) begin
      rchk(4'(i), rst_exp[i]);
    end
    rchk(4'hf, 16'h0000);
    chk({14'h0, relay, pwr}, 16'h0003);
    // small command passes unchanged
    cmd <= 9'sd30;
    step(3);
    chk({7'h0, cmd_o}, 16'h001e);
    // negative command keeps its sign
    cmd <= -9'sd30;
    step(3);
    chk({7'h0, cmd_o}, 16'h01e2);
    // fusing overload at twice rated: clamp, then trip
    wreg(REG_MASK, 16'h0001);
    cmd <= 9'sd100;
    i = 0;
    while (cmd_o !== 9'sd50 && i < 11000) begin
      @(posedge clk_in);
      i++;
    end
    chk({15'h0, i < 10000}, 16'h0001);
    step(2);
    chk({15'h0, irq}, 16'h0000);
    j = 0;
    while (pwr === 1'b1 && j < 20000) begin
      @(posedge clk_in);
      j++;
    end
    chk({15'h0, j > 16400 && j < 16600}, 16'h0001);
    step(2);
    chk({14'h0, relay, irq}, 16'h0001);
    rchk(REG_STATE, 16'h3203);
    rchk(REG_STAT, 16'h0009);
    wreg(REG_STAT, 16'h0009);
    step(2);
    chk({14'h0, irq, pwr}, 16'h0000);
    cmd <= 9'sd0;
    clear_faults();
    chk({14'h0, relay, pwr}, 16'h0003);
    overload_hold(16'h0000, 16'h0005);
    overload_hold(16'h0001, 16'h000a);
    // clamp reached in limiting mode, then fusing with max equal to rated
    cmd <= 9'sd100;
    step(200);
    wreg(REG_MAX, 16'h0005);
    wreg(REG_CTRL, 16'h0000);
    step(8000);
    chk({14'h0, relay, pwr}, 16'h0003);
    cmd <= 9'sd0;
    step(20);
    // thermal cases; warning never beyond trip for the chosen probe
    for (i = 0; i < 6; i++) begin
      probe <= (i >= 3) ? 16'h03e8 : 16'h1388;
      wreg(REG_CTRL, (i >= 3) ? 16'h0002 : 16'h0000);
      wreg(REG_WARN, (i >= 3) ? 16'h07d0 : 16'h0fa0);
      wreg(REG_TRIP, 16'h0ce4);
      clear_faults();
      probe <= th_ohm[i];
      step(6);
      chk({14'h0, warn, pwr}, {14'h0, th_exp[i]});
      chk({15'h0, relay}, {15'h0, th_exp[i][0]});
      if (i == 2) begin
        rchk(REG_STAT, 16'h0006);
      end
    end
    probe <= 16'h03e8;
    clear_faults();
    // disabled drive refuses the command
    cmd <= 9'sd30;
    drv_en <= 1'b0;
    step(6);
    chk({6'h0, pwr, cmd_o}, 16'h0000);
    // torque mode with zero command gives no current
    drv_en <= 1'b1;
    trq_sel <= 1'b1;
    cmd <= 9'sd0;
    step(8);
    chk({cmd_o[7:0], meas}, 16'h0000);
    give_verdict();
  end
endmodule
